// ### common/ccpc_pkg.sv
// Purpose: constants, field layouts and access ranges of the charge control and pack option block
// Assumes: one 250 MHz core clock; configuration bytes loaded over the register port
// Notes: temperatures are in 0.1 degC, voltages in mV, currents in mA (charge positive)
//
// Functional notes
// - after termination report zero, then maintenance rate (byte x 4 mA) once condition ends
// - below lowest discharge end threshold report precharge rate (byte x 8 mA)
// - between 0 degC and low threshold (nibble x 0.8 degC) report precharge rate
// - charge current above request plus margin (byte x 16 mA) forces zero request
// - suspend charge above 69 degC minus upper nibble x 1.6 degC
// - suspend fast charge once charge past full reaches the overcharge limit; never reached, as the fully charged flag is always clear in fast charge
// - clear fully charged flag when relative charge reaches the clear percentage
// - with coulomb sync, termination loads remaining capacity with a set share of full capacity
// - count one cycle each time the threshold charge has been removed
// - taper termination after voltage high and current low held for 40 seconds
// - option bit 7 picks absolute or relative charge for the LED display
// - bus_access_lock bit locks bus access to the listed command ranges
// - option bit 4 picks fixed or computed discharge end thresholds
// - option bit 3 enables continuous midrange fix, bit 1 a single one after reset
// - option bit 2 picks external thermistor over the internal sensor
// - option bit 0 picks four series cells over three
// - delay bit requires two successive faulty cell readings before the flag sets
// - discharge end source bit picks pack voltage over lowest cell voltage
// - learning stays qualified only if discharge exceeds C/32 or 3C/32 at checkpoints
// - learning disabled below 12 degC or the stored low temperature threshold
// - time and capacity alarm bytes are thresholds for the two alarm commands
// - cell overvoltage 4096 + 32 mV steps, undervoltage 2048 + 64 mV steps
package ccpc_pkg;
  localparam longint unsigned CLK_HZ = 250_000_000;
  localparam longint unsigned TAPER_HOLD_S = 40;
  localparam longint unsigned TAPER_HOLD_CYCLES = TAPER_HOLD_S * CLK_HZ;
  localparam int TAPER_CNT_W = $clog2(TAPER_HOLD_CYCLES + 1);

  // configuration byte offsets (16-bit values: low byte first)
  localparam int CFG_BYTES = 128;
  localparam int OFF_TIME_ALARM = 'h02;
  localparam int OFF_CAP_ALARM = 'h04;
  localparam int OFF_MAINT = 'h1D;
  localparam int OFF_PRECHG = 'h1E;
  localparam int OFF_OVERCHG = 'h2E;
  localparam int OFF_CYCLE_THR = 'h3C;
  localparam int OFF_PACK_OPT = 'h3F;
  localparam int OFF_TEMP_PAIR = 'h45;
  localparam int OFF_OC_MARGIN = 'h49;
  localparam int OFF_CELL_LIM = 'h4A;
  localparam int OFF_TERM_PCT = 'h4B;
  localparam int OFF_FULL_CLR = 'h4C;
  localparam int OFF_TAPER_I = 'h4E;
  localparam int OFF_TAPER_V = 'h4F;
  localparam int OFF_PACK_PROG = 'h63;
  localparam int OFF_LOWEST_DISCHARGE_END_THRESHOLD = 'h72;
  localparam int OFF_EDV2 = 'h78;
  // block state, read only; configuration reset value
  localparam logic [7:0] OFF_STATUS = 8'h80;
  localparam logic [7:0] OFF_CYC_LO = 8'h81;
  localparam logic [7:0] OFF_CYC_HI = 8'h82;
  localparam logic [7:0] CFG_RESET = 8'h00;

  // pack option bits
  localparam int PO_LED_SRC = 7;
  localparam int PO_BUS_ACCESS_LOCK = 6;
  localparam int PO_COULOMB_SYNC_ON_TERMINATION = 5;
  localparam int PO_DISCHARGE_END_COMPENSATION = 4;
  localparam int PO_CONTINUOUS_MIDRANGE_FIX = 3;
  localparam int PO_EXTERNAL_TEMP_SELECT = 2;
  localparam int PO_SINGLE_MIDRANGE_FIX = 1;
  localparam int PO_FOUR = 0;
  // pack programming bits
  localparam int PP_LEARN_TEMP_FAULT_SELECT = 4;
  localparam int PP_LEARN_CURRENT_FLOOR = 3;
  localparam int PP_DISCHARGE_END_SOURCE = 2;
  localparam int PP_PROTECTION_FAULT_DELAY = 0;

  // encodings
  localparam int MAINT_MA_PER_LSB = 4;
  localparam int PRECHG_MA_PER_LSB = 8;
  localparam int MARGIN_MA_PER_LSB = 16;
  localparam int LOWT_DC_PER_LSB = 8;
  localparam int MAXT_BASE_DC = 690;
  localparam int MAXT_DC_PER_LSB = 16;
  localparam int TAPER_QUALIFY_MV_MV_PER_LSB = 2;
  localparam int TAPER_MA_PER_LSB = 1;
  localparam int OV_BASE_MV = 4096;
  localparam int OV_MV_PER_LSB = 32;
  localparam int UV_BASE_MV = 2048;
  localparam int UV_MV_PER_LSB = 64;
  localparam int LEARN_FAULT_DC = 120;
  localparam int LEARN_FLOOR_SHIFT = 5;
  localparam int LEARN_FLOOR_MUL = 3;

  typedef enum logic [2:0] {
    CCPC_FAST = 3'b001,
    CCPC_TERM = 3'b010,
    CCPC_MAINT = 3'b100
  } ccpc_chg_e;

  function automatic logic ccpc_wr_ok(input logic [7:0] a, input logic sealed);
    ccpc_wr_ok = !a[7] && (!sealed || a <= 8'h04 || a == 8'h2F || (a >= 8'h3C && a <= 8'h3F));
  endfunction

  function automatic logic ccpc_rd_ok(input logic [7:0] a, input logic sealed);
    ccpc_rd_ok = ccpc_wr_ok(a, sealed) || (sealed && ((a >= 8'h05 && a <= 8'h1C) || (a >= 8'h20 && a <= 8'h23)));
  endfunction
endpackage

// ### src/ccpc_hold_timer.sv
// Purpose: one pulse once a condition has held for a set number of cycles
// Assumes: cond from logic on the same clock
// Notes: fires once per unbroken hold; cond must drop before it can fire again
`timescale 1ns/1ps
module ccpc_hold_timer import ccpc_pkg::*; #(
  parameter longint unsigned CYCLES = TAPER_HOLD_CYCLES
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // condition and result
  input wire logic cond,
  output logic fired
);
  localparam logic [TAPER_CNT_W-1:0] LAST = TAPER_CNT_W'(CYCLES - 1);
  logic [TAPER_CNT_W-1:0] cnt;
  logic held;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cnt <= '0;
      held <= 1'b0;
    end else if (!cond) begin
      cnt <= '0;
      held <= 1'b0;
    end else if (!held) begin
      if (cnt == LAST) begin
        held <= 1'b1;
      end else begin
        cnt <= cnt + 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      fired <= 1'b0;
    end else begin
      fired <= cond && !held && cnt == LAST;
    end
  end

  hold_fire_a: assert property (@(posedge ref_clk) disable iff (rst)
    (cond && !held && cnt == LAST) |=> fired ##1 !fired) else $error("hold timer did not fire once");
endmodule

// ### src/ccpc_fault_filter.sv
// Purpose: cell under/over voltage flag with optional two-reading confirmation
// Assumes: meas_stb marks each cell measurement, nominally every 2 s
// Notes: flag follows the latest reading, or the latest two when confirmation is on; a good reading clears it
`timescale 1ns/1ps
module ccpc_fault_filter (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // measurement
  input wire logic meas_stb,
  input wire logic fault,
  input wire logic two_needed,
  // result
  output logic flag
);
  logic prev_fault;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      prev_fault <= 1'b0;
      flag <= 1'b0;
    end else if (meas_stb) begin
      prev_fault <= fault;
      flag <= fault && (!two_needed || prev_fault);
    end
  end

  one_fault_a: assert property (@(posedge ref_clk) disable iff (rst)
    (meas_stb && fault && two_needed && !prev_fault) |=> !flag) else $error("flag set on single fault");
  two_fault_a: assert property (@(posedge ref_clk) disable iff (rst)
    (meas_stb && fault && (!two_needed || prev_fault)) |=> flag) else $error("flag missed fault");
endmodule

// ### src/ccpc_top.sv
// Purpose: charge current selection and pack option decode of a battery gauge
// Assumes: all measurement inputs come from logic on ref_clk
// Notes: configuration image lives in flip-flops and is written over the register port
`timescale 1ns/1ps
module ccpc_top import ccpc_pkg::*; #(
  parameter longint unsigned TAPER_HOLD_CYC = TAPER_HOLD_CYCLES
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // measurements
  input wire logic [15:0] pack_mv,
  input wire logic [15:0] lowest_cell_mv,
  input wire logic [15:0] highest_cell_mv,
  input wire logic cell_meas_stb,
  input wire logic signed [15:0] current_ma,
  input wire logic signed [15:0] temp_dc,
  input wire logic [15:0] charging_voltage_mv,
  input wire logic [15:0] fast_current_ma,
  input wire logic [15:0] full_charge_capacity,
  input wire logic [7:0] rsoc_pct,
  input wire logic charge_mah_stb,
  input wire logic discharge_mah_stb,
  input wire logic [15:0] edv_calc0_mv,
  input wire logic [15:0] edv_calc2_mv,
  input wire logic low_battery_reached,
  input wire logic learn_start,
  input wire logic midrange_fix_done,
  input wire logic [15:0] remaining_time_min,
  input wire logic [15:0] remaining_capacity,
  // charge control
  output logic [15:0] charging_current_ma,
  output logic full_charged,
  output logic taper_terminated,
  output logic rm_load,
  output logic [15:0] rm_load_value,
  output logic [15:0] cycle_count,
  // pack options
  output logic led_display_source,
  output logic bus_access_lock,
  output logic discharge_end_compensation,
  output logic midrange_fix_enable,
  output logic external_temp_select,
  output logic four_series_select,
  output logic at_lowest_discharge_end,
  // protection and learning
  output logic cell_undervolt_flag,
  output logic cell_overvolt_flag,
  output logic learn_qualified,
  output logic learn_temp_fault,
  output logic time_alarm,
  output logic capacity_alarm
);
  logic [7:0] cfg_mem [CFG_BYTES];
  ccpc_chg_e cur_state;
  ccpc_chg_e next_state;
  logic [7:0] pack_opt, pack_prog, temp_pair, cell_lim;
  logic [15:0] maint_ma, pre_ma, margin_ma, lowest_discharge_end_threshold, edv2, end_v, ov_mv, uv_mv;
  logic [15:0] overchg_mag, cycle_mag, overchg_acc, removed_acc;
  logic signed [15:0] max_temp_dc, low_temp_dc, learn_temp_dc;
  logic signed [17:0] discharge_ma, learn_floor, taper_v_min;
  logic charging, below_lowest_discharge_end_threshold, at_edv2, low_temp, over_temp, oc_hit, oc_susp;
  logic zero_req, pre_req, taper_cond, taper_done, overchg_hit, term_evt, clear_hit;
  logic cyc_hit, one_time_done, wr_take, taper_seen;
  logic [7:0] next_rdata;
  logic [1:0] cell_fault, cell_flag;

  function automatic logic [15:0] cfg16(input int off);
    cfg16 = {cfg_mem[off + 1], cfg_mem[off]};
  endfunction

  // configuration image
  assign wr_take = reg_wr && ccpc_wr_ok(reg_addr, bus_access_lock);
  for (genvar gi = 0; gi < CFG_BYTES; gi++) begin : g_cfg
    always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
        cfg_mem[gi] <= CFG_RESET;
      end else if (wr_take && reg_addr[6:0] == 7'(gi)) begin
        cfg_mem[gi] <= reg_wdata;
      end
    end
  end

  assign pack_opt = cfg_mem[OFF_PACK_OPT];
  assign pack_prog = cfg_mem[OFF_PACK_PROG];
  assign temp_pair = cfg_mem[OFF_TEMP_PAIR];
  assign cell_lim = cfg_mem[OFF_CELL_LIM];

  // lock sets on any accepted pack option write with the bus_access_lock bit set and stays until the next reset
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      bus_access_lock <= 1'b0;
    end else if (wr_take && reg_addr == 8'(OFF_PACK_OPT) && reg_wdata[PO_BUS_ACCESS_LOCK]) begin
      bus_access_lock <= 1'b1;
    end
  end

  // register read, data valid only in the cycle after the strobe
  always_comb begin
    next_rdata = 8'h00;
    if (!reg_addr[7]) begin
      if (ccpc_rd_ok(reg_addr, bus_access_lock)) begin
        next_rdata = cfg_mem[reg_addr[6:0]];
      end
    end else if (reg_addr == OFF_STATUS) begin
      next_rdata = {1'b0, learn_qualified, cell_overvolt_flag, cell_undervolt_flag,
                    bus_access_lock, oc_susp, taper_terminated, full_charged};
    end else if (reg_addr == OFF_CYC_LO) begin
      next_rdata = cycle_count[7:0];
    end else if (reg_addr == OFF_CYC_HI) begin
      next_rdata = cycle_count[15:8];
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= reg_rd ? next_rdata : 8'h00;
    end
  end

  // decoded thresholds
  assign maint_ma = 16'(MAINT_MA_PER_LSB * cfg_mem[OFF_MAINT]);
  assign pre_ma = 16'(PRECHG_MA_PER_LSB * cfg_mem[OFF_PRECHG]);
  assign margin_ma = 16'(MARGIN_MA_PER_LSB * cfg_mem[OFF_OC_MARGIN]);
  assign low_temp_dc = 16'(LOWT_DC_PER_LSB * temp_pair[3:0]);
  assign max_temp_dc = 16'(MAXT_BASE_DC - MAXT_DC_PER_LSB * temp_pair[7:4]);
  assign ov_mv = 16'(OV_BASE_MV + OV_MV_PER_LSB * cell_lim[3:0]);
  assign uv_mv = 16'(UV_BASE_MV + UV_MV_PER_LSB * cell_lim[7:4]);
  // limits are stored negated
  assign overchg_mag = 16'(-cfg16(OFF_OVERCHG));
  assign cycle_mag = 16'(-cfg16(OFF_CYCLE_THR));
  assign lowest_discharge_end_threshold = pack_opt[PO_DISCHARGE_END_COMPENSATION] ? edv_calc0_mv : cfg16(OFF_LOWEST_DISCHARGE_END_THRESHOLD);
  assign edv2 = pack_opt[PO_DISCHARGE_END_COMPENSATION] ? edv_calc2_mv : cfg16(OFF_EDV2);
  assign end_v = pack_prog[PP_DISCHARGE_END_SOURCE] ? pack_mv : lowest_cell_mv;

  // charge conditions
  assign charging = current_ma > 16'sh0000;
  assign below_lowest_discharge_end_threshold = end_v < lowest_discharge_end_threshold;
  assign at_edv2 = end_v < edv2;
  assign low_temp = temp_dc >= 16'sh0000 && temp_dc < low_temp_dc;
  assign over_temp = temp_dc > max_temp_dc;
  assign oc_hit = charging && 18'(current_ma) > $signed({2'b00, charging_current_ma} + {2'b00, margin_ma});
  assign taper_v_min = $signed({2'b00, charging_voltage_mv}) - 18'(TAPER_QUALIFY_MV_MV_PER_LSB * cfg_mem[OFF_TAPER_V]);
  // judged without the state so that TERM holds zero until the taper condition really ends
  assign taper_seen = charging && $signed({2'b00, pack_mv}) > taper_v_min &&
                      18'(current_ma) < 18'(TAPER_MA_PER_LSB * cfg_mem[OFF_TAPER_I]);
  assign taper_cond = cur_state == CCPC_FAST && taper_seen;
  assign overchg_hit = cur_state == CCPC_FAST && full_charged && overchg_acc >= overchg_mag;
  assign term_evt = cur_state == CCPC_FAST && (taper_done || overchg_hit);
  assign zero_req = cur_state == CCPC_TERM || oc_susp || over_temp;
  assign pre_req = below_lowest_discharge_end_threshold || low_temp;
  assign clear_hit = $signed({1'b0, rsoc_pct}) <= -$signed({cfg_mem[OFF_FULL_CLR][7], cfg_mem[OFF_FULL_CLR]});

  ccpc_hold_timer #(
    .CYCLES(TAPER_HOLD_CYC)
  ) u_taper (
    .ref_clk(ref_clk),
    .rst(rst),
    .cond(taper_cond),
    .fired(taper_done)
  );

  // charge state
  always_comb begin
    next_state = cur_state;
    unique case (cur_state)
      CCPC_FAST: if (term_evt) next_state = CCPC_TERM;
      CCPC_TERM: if (!taper_seen && !overchg_hit) next_state = CCPC_MAINT;
      CCPC_MAINT: if (!full_charged) next_state = CCPC_FAST;
      default: next_state = CCPC_FAST;
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cur_state <= CCPC_FAST;
    end else begin
      cur_state <= next_state;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      charging_current_ma <= 16'h0000;
    end else if (zero_req) begin
      charging_current_ma <= 16'h0000;
    end else if (pre_req) begin
      charging_current_ma <= pre_ma;
    end else if (cur_state == CCPC_MAINT) begin
      charging_current_ma <= maint_ma;
    end else begin
      charging_current_ma <= fast_current_ma;
    end
  end

  // overcurrent suspension holds until charging stops
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      oc_susp <= 1'b0;
    end else if (oc_hit) begin
      oc_susp <= 1'b1;
    end else if (!charging) begin
      oc_susp <= 1'b0;
    end
  end

  // charge accepted past full
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      overchg_acc <= 16'h0000;
    end else if (cur_state != CCPC_FAST || !full_charged) begin
      overchg_acc <= 16'h0000;
    end else if (charge_mah_stb && overchg_acc != 16'hFFFF) begin
      overchg_acc <= overchg_acc + 16'h0001;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      full_charged <= 1'b0;
      taper_terminated <= 1'b0;
    end else begin
      if (term_evt) begin
        full_charged <= 1'b1;
      end else if (clear_hit) begin
        full_charged <= 1'b0;
      end
      if (taper_done) begin
        taper_terminated <= 1'b1;
      end else if (cur_state == CCPC_MAINT && !full_charged) begin
        taper_terminated <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rm_load <= 1'b0;
      rm_load_value <= 16'h0000;
    end else begin
      rm_load <= term_evt && pack_opt[PO_COULOMB_SYNC_ON_TERMINATION];
      if (term_evt && pack_opt[PO_COULOMB_SYNC_ON_TERMINATION]) begin
        rm_load_value <= 16'((25'(full_charge_capacity) * (25'(cfg_mem[OFF_TERM_PCT]) + 25'h1)) >> 8);
      end
    end
  end

  // cycle counting on removed charge
  assign cyc_hit = discharge_mah_stb && removed_acc + 16'h0001 >= cycle_mag;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      removed_acc <= 16'h0000;
      cycle_count <= 16'h0000;
    end else if (cyc_hit) begin
      removed_acc <= 16'h0000;
      cycle_count <= cycle_count + 16'h0001;
    end else if (discharge_mah_stb) begin
      removed_acc <= removed_acc + 16'h0001;
    end
  end

  // option decode
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      led_display_source <= 1'b0;
      discharge_end_compensation <= 1'b0;
      external_temp_select <= 1'b0;
      four_series_select <= 1'b0;
      at_lowest_discharge_end <= 1'b0;
      midrange_fix_enable <= 1'b0;
      one_time_done <= 1'b0;
    end else begin
      led_display_source <= pack_opt[PO_LED_SRC];
      discharge_end_compensation <= pack_opt[PO_DISCHARGE_END_COMPENSATION];
      external_temp_select <= pack_opt[PO_EXTERNAL_TEMP_SELECT];
      four_series_select <= pack_opt[PO_FOUR];
      at_lowest_discharge_end <= below_lowest_discharge_end_threshold;
      one_time_done <= one_time_done || midrange_fix_done;
      midrange_fix_enable <= pack_opt[PO_CONTINUOUS_MIDRANGE_FIX] || (pack_opt[PO_SINGLE_MIDRANGE_FIX] && !one_time_done && !midrange_fix_done);
    end
  end

  // cell protection
  assign cell_fault = {highest_cell_mv > ov_mv, lowest_cell_mv < uv_mv};
  for (genvar gf = 0; gf < 2; gf++) begin : g_cell
    ccpc_fault_filter u_filt (
      .ref_clk(ref_clk),
      .rst(rst),
      .meas_stb(cell_meas_stb),
      .fault(cell_fault[gf]),
      .two_needed(pack_prog[PP_PROTECTION_FAULT_DELAY]),
      .flag(cell_flag[gf])
    );
  end
  assign cell_undervolt_flag = cell_flag[0];
  assign cell_overvolt_flag = cell_flag[1];

  // learning qualification
  assign discharge_ma = -18'(current_ma);
  assign learn_floor = pack_prog[PP_LEARN_CURRENT_FLOOR] ? 18'(full_charge_capacity >> LEARN_FLOOR_SHIFT) :
                       18'((LEARN_FLOOR_MUL * full_charge_capacity) >> LEARN_FLOOR_SHIFT);
  assign learn_temp_dc = pack_prog[PP_LEARN_TEMP_FAULT_SELECT] ? low_temp_dc : 16'(LEARN_FAULT_DC);
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      learn_qualified <= 1'b0;
      learn_temp_fault <= 1'b0;
    end else begin
      learn_temp_fault <= temp_dc < learn_temp_dc;
      if (learn_start) begin
        learn_qualified <= 1'b1;
      end else if (temp_dc < learn_temp_dc ||
                   ((low_battery_reached || at_edv2) && discharge_ma <= learn_floor)) begin
        learn_qualified <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      time_alarm <= 1'b0;
      capacity_alarm <= 1'b0;
    end else begin
      time_alarm <= remaining_time_min < cfg16(OFF_TIME_ALARM);
      capacity_alarm <= remaining_capacity < cfg16(OFF_CAP_ALARM);
    end
  end

  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);

  maint_rate_a: assert property ((cur_state == CCPC_MAINT && !zero_req && !pre_req)
    |=> charging_current_ma == $past(maint_ma)) else $error("maintenance rate wrong");
  precharge_rate_a: assert property ((!zero_req && pre_req)
    |=> charging_current_ma == $past(pre_ma)) else $error("precharge rate wrong");
  low_temp_a: assert property ((!zero_req && low_temp) |=> charging_current_ma == $past(pre_ma))
    else $error("cold precharge missing");
  overcurrent_a: assert property (oc_hit |=> oc_susp ##1 (charging_current_ma == 16'h0000 || !$past(oc_susp)))
    else $error("overcurrent not suspended");
  hot_suspend_a: assert property (over_temp |=> charging_current_ma == 16'h0000)
    else $error("hot charge not suspended");
  overcharge_a: assert property (overchg_hit |=> cur_state == CCPC_TERM && full_charged)
    else $error("overcharge not suspended");
  full_clear_a: assert property ((full_charged && clear_hit && !term_evt) |=> !full_charged)
    else $error("full flag not cleared");
  rm_sync_a: assert property (term_evt |=> rm_load == $past(pack_opt[PO_COULOMB_SYNC_ON_TERMINATION]))
    else $error("sync load wrong");
  cycle_step_a: assert property (cyc_hit |=> cycle_count == $past(cycle_count) + 16'h0001 && removed_acc == 16'h0000)
    else $error("cycle count missed");
  taper_term_a: assert property (taper_done && cur_state == CCPC_FAST |=> taper_terminated && cur_state == CCPC_TERM)
    else $error("taper not terminated");
  sealed_read_a: assert property ((reg_rd && bus_access_lock && !reg_addr[7] && !ccpc_rd_ok(reg_addr, 1'b1))
    |=> reg_rdata == 8'h00) else $error("sealed read leaked");
  zero_first_a: assert property ((zero_req && pre_req) |=> charging_current_ma == 16'h0000)
    else $error("precharge beat suspension");
endmodule

// ### tb/ccpc_charger.sv
// Purpose: smart charger stand-in that delivers the requested current
// Assumes: request comes from the block on ref_clk
// Notes: one cycle of lag, so the margin must cover a falling request
`timescale 1ns/1ps
module ccpc_charger (
  // clock
  input wire logic ref_clk,
  // request and delivery
  input wire logic [15:0] req,
  output logic signed [15:0] cur
);
  always_ff @(posedge ref_clk) begin
    cur <= req;
  end
endmodule

// ### tb/ccpc_test.sv
// Purpose: self-checking bench of the charge control and pack option block
// Assumes: register port driven right after rising edges
// Notes: taper hold shortened to 20 cycles
`timescale 1ns/1ps
module ccpc_test;
  import ccpc_pkg::*;
  logic ref_clk = 0, rst = 1, wr = 0, rd = 0, dst = 0, lk = 0;
  logic tt, led, lock, ced, ext, four, ta, fl, uvf, ovf, atl, lq, low_temp_threshold, ca, mfe;
  logic [7:0] a = 0, d = 0, q, ob, mb, pb, rs = 8'h50;
  logic [15:0] pmv = 16'h1388, lc = 16'h0DAC, cc, rv, cyo, fc, rt = 16'h0005;
  logic signed [15:0] cur, t = 16'sh00FA;
  logic [16:0] lf = 17'd70891;
  int n_errors = 0, samples_checked = 0, cyc = 0, m[256];
  ccpc_charger chg_u (.ref_clk(ref_clk), .req(cc), .cur(cur));
  ccpc_top #(.TAPER_HOLD_CYC(20)) dut_u (.ref_clk(ref_clk), .rst(rst), .reg_addr(a), .reg_wdata(d),
    .reg_wr(wr), .reg_rd(rd), .reg_rdata(q), .pack_mv(pmv), .lowest_cell_mv(lc), .highest_cell_mv(lc),
    .cell_meas_stb(dst), .current_ma(cur), .temp_dc(t), .charging_voltage_mv(16'h2EE0),
    .fast_current_ma(fc), .full_charge_capacity(16'h03E8), .rsoc_pct(rs), .charge_mah_stb(1'b0),
    .discharge_mah_stb(dst), .edv_calc0_mv(lc), .edv_calc2_mv(lc), .low_battery_reached(1'b0),
    .learn_start(dst), .midrange_fix_done(dst), .remaining_time_min(rt), .remaining_capacity(pmv),
    .charging_current_ma(cc), .full_charged(fl), .taper_terminated(tt), .rm_load(), .rm_load_value(rv),
    .cycle_count(cyo), .led_display_source(led), .bus_access_lock(lock), .discharge_end_compensation(ced),
    .midrange_fix_enable(mfe), .external_temp_select(ext), .four_series_select(four),
    .at_lowest_discharge_end(atl), .cell_undervolt_flag(uvf), .cell_overvolt_flag(ovf), .learn_qualified(lq),
    .learn_temp_fault(low_temp_threshold), .time_alarm(ta), .capacity_alarm(ca));
  initial begin
    forever #2 ref_clk = ~ref_clk;
  end
  task automatic end_sim;
    if (n_errors == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] g, input int e);
    samples_checked++;
    if (g !== e[15:0]) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e[15:0]);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic wrb(input int ad, input int v);
    @(posedge ref_clk);
    a <= ad[7:0];
    d <= v[7:0];
    wr <= 1'b1;
    @(posedge ref_clk);
    wr <= 1'b0;
    if (ad < 'h80 && (!lk || ad <= 4 || ad == 'h2F || (ad >= 'h3C && ad <= 'h3F))) m[ad] = v & 'hFF;
  endtask
  task automatic rdc(input int ad);
    @(posedge ref_clk);
    a <= ad[7:0];
    rd <= 1'b1;
    @(posedge ref_clk);
    rd <= 1'b0;
    #1;
    // a locked port still reads the status range
    chk(q, (!lk || ad <= 4 || (ad >= 5 && ad <= 'h1C) || (ad >= 'h20 && ad <= 'h23) || ad == 'h2F
      || (ad >= 'h3C && ad <= 'h3F)) && ad < 'h80 ? m[ad] : 0);
  endtask
  function automatic logic [16:0] nx(input logic [16:0] s);
    return {s[15:0], s[16] ^ s[13]};
  endfunction
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_errors++;
      end_sim();
    end
  end
  initial begin
    lf = nx(lf);
    fc = {9'h000, lf[6:0]} + 16'h0001;
    mb = lf[14:7];
    lf = nx(lf);
    pb = lf[7:0];
    ob = {lf[15], 2'b01, 1'b0, lf[11:8]};
    tick(4);
    rst <= 1'b0;
    foreach (m[i]) m[i] = 0;
    wrb('h1D, mb);
    wrb('h1E, pb);
    wrb('h45, 'h25);
    wrb('h49, 'hFF);
    wrb('h4E, 'hFF);
    wrb('h4F, 'h10);
    wrb('h4B, 'h7F);
    wrb('h3F, ob);
    rdc('h1D);
    rdc('h45);
    rdc('h90);
    tick(2);
    chk({led, ced, ext, four, mfe}, {ob[7], ob[4], ob[2], ob[0], ob[3] | ob[1]});
    chk(cc, fc);
    pmv <= 16'h2EE0;
    for (int i = 0; i < 100 && tt !== 1'b1; i++) tick(1);
    chk({tt, fl}, 3);
    tick(2);
    chk(cc, 0);
    chk(rv, 500);
    pmv <= 16'h1388;
    tick(4);
    chk(cc, mb * 4);
    wrb('h72, 'hB8);
    wrb('h73, 'h0B);
    lc <= 16'h09C4;
    tick(3);
    chk(cc, pb * 8);
    lc <= 16'h0DAC;
    t <= 16'sh0014;
    tick(3);
    chk(cc, pb * 8);
    chk(low_temp_threshold, 1);
    t <= 16'sh02BC;
    tick(3);
    chk(cc, 0);
    t <= 16'sh00FA;
    wrb('h3C, 'hFD);
    wrb('h3D, 'hFF);
    wrb('h4A, 'hF0);
    lc <= 16'h09C4;
    repeat (6) begin
      dst <= 1'b1;
      tick(1);
      dst <= 1'b0;
      tick(1);
    end
    chk(cyo, 2);
    chk({uvf, ovf}, 2);
    chk(atl, 1);
    chk(lq, 1);
    chk(mfe, ob[3]);
    lc <= 16'h0DAC;
    wrb('h02, 'h10);
    wrb('h05, 'h20);
    tick(2);
    chk({ta, ca}, 3);
    rs <= 8'h00;
    tick(2);
    chk(fl, 0);
    wrb('h3F, ob | 'h40);
    lk = 1;
    tick(1);
    chk(lock, 1);
    wrb('h1D, 'h55);
    rdc('h1D);
    rdc('h3C);
    rdc('h10);
    end_sim();
  end
endmodule
